// ==== rtl/dcc_top.sv ====
/*
 Configuration control of an octal 16-bit converter: configuration register,
 channel data registers, gain and zero registers, output latches, offset reload.
 Assumes a serial front end delivering one decoded access per cycle on host_req,
 and an async load pin already synchronous to sys_clk.
*/
// What this block does
// - Readback select 0 returns input data, 1 returns converter data register.
// - With correction on, input holds host word, converter register the corrected word.
// - Configuration register resets to 8000h: readback select 1, rest 0.
// - Load pin high: sync update waits for writes and correction, then loads together.
// - Sync update reloads only latches written since last load pulse or update.
// - Sync update bit clears itself once its latch update is done.
// - Correction off: sync update loads latches at once when set.
// - Sync update bit is ignored while the load pin is low.
// - Software reset bit acts like hardware reset and reads back 0.
// - Group A power-down floats channels 0 to 3; interface stays active.
// - Group B power-down floats channels 4 to 7; interface stays active.
// - Correction on: gain and zero adjust each word before the converter register.
// - Correction off: input word copied straight to converter register, then latch.
// - Configuration bit 9 is reserved: writes ignored, reads 0.
// - Group A span change reloads offset A with the trimmed code.
// - Group A span bit: 0 gives six times reference, 1 gives four times.
// - Group B span change reloads offset B with the trimmed code.
// - Group B span bit: 0 gives six times reference, 1 gives four times.
`timescale 1ns/10ps
`include "dcc_defs.svh"

module dcc_top (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire dcc_pkg::dcc_req_s host_req,
    output dcc_pkg::dcc_word_t host_rdata,
    output logic host_rvalid,
    input wire logic async_load_pin,
    input wire dcc_pkg::dcc_trim_s trim_a,
    input wire dcc_pkg::dcc_trim_s trim_b,
    output logic [7:0][15:0] dac_latch,
    output logic [7:0] output_enable,
    output logic group_a_powerdown,
    output logic group_b_powerdown,
    output logic span_a_x4,
    output logic span_b_x4,
    output dcc_pkg::dcc_word_t offset_a,
    output dcc_pkg::dcc_word_t offset_b,
    output logic correction_busy
);

    // ----------------------------------------------------------------------
    // State.
    // ----------------------------------------------------------------------
    dcc_pkg::dcc_cfg_s cfg;
    dcc_pkg::dcc_cfg_s next_cfg;
    dcc_pkg::dcc_word_t in_reg [8];
    dcc_pkg::dcc_word_t next_in_reg [8];
    dcc_pkg::dcc_word_t dac_reg [8];
    dcc_pkg::dcc_word_t next_dac_reg [8];
    dcc_pkg::dcc_word_t gain_reg [8];
    dcc_pkg::dcc_word_t next_gain_reg [8];
    dcc_pkg::dcc_word_t zero_reg [8];
    dcc_pkg::dcc_word_t next_zero_reg [8];
    logic [7:0][15:0] next_dac_latch;
    logic [7:0] accessed;
    logic [7:0] next_accessed;
    logic [7:0] pend;
    logic [7:0] next_pend;
    dcc_pkg::dcc_word_t next_offset_a;
    dcc_pkg::dcc_word_t next_offset_b;
    dcc_pkg::dcc_word_t next_host_rdata;
    logic next_host_rvalid;
    logic soft_rst;
    logic next_soft_rst;

    // ----------------------------------------------------------------------
    // Decode and engine hand-off.
    // ----------------------------------------------------------------------
    logic [4:0] bank;
    dcc_pkg::dcc_ch_t ach;
    logic eng_busy;
    logic eng_done;
    dcc_pkg::dcc_ch_t eng_done_ch;
    dcc_pkg::dcc_word_t eng_result;
    logic eng_start;
    dcc_pkg::dcc_ch_t eng_ch;
    logic fire;
    logic reload_a;
    logic reload_b;
    dcc_pkg::dcc_word_t code_a;
    dcc_pkg::dcc_word_t code_b;


    // ----------------------------------------------------------------------
    // Combinational outputs.
    // ----------------------------------------------------------------------
    assign bank = host_req.addr & `DCC_ADDR_BANK_MASK;
    assign ach = host_req.addr[2:0];
    // Busy until the engine's result has landed, so a sync update never loads a stale channel.
    assign correction_busy = eng_busy | eng_done | (|pend);
    assign group_a_powerdown = cfg.group_a_powerdown;
    assign group_b_powerdown = cfg.group_b_powerdown;
    assign span_a_x4 = cfg.span_a;
    assign span_b_x4 = cfg.span_b;

    // ----------------------------------------------------------------------
    // Output enables.
    // ----------------------------------------------------------------------
    // Output buffers float per group while powered down.
    genvar g;
    generate
        for (g = 0; g < `DCC_NUM_CH; g = g + 1) begin : gen_oe
            if (g < 4) begin : gen_a
                assign output_enable[g] = ~cfg.group_a_powerdown;
            end else begin : gen_b
                assign output_enable[g] = ~cfg.group_b_powerdown;
            end
        end
    endgenerate

    // ----------------------------------------------------------------------
    // Correction queue.
    // ----------------------------------------------------------------------
    // Lowest pending channel goes to the engine when it is idle.
    always_comb begin
        eng_ch = 3'h0;
        eng_start = 1'b0;
        for (int i = `DCC_NUM_CH - 1; i >= 0; i--) begin
            if (pend[i]) begin
                eng_ch = 3'(i);
                eng_start = ~eng_busy;
            end
        end
    end

    // ----------------------------------------------------------------------
    // Latch update.
    // ----------------------------------------------------------------------
    // Sync update fires only with the load pin high and all correction finished.
    assign fire = cfg.sync_latch_update & async_load_pin & ~correction_busy;

    // ----------------------------------------------------------------------
    // Submodules.
    // ----------------------------------------------------------------------
    dcc_correct u_correct (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .clear(soft_rst),
        .start(eng_start),
        .start_ch(eng_ch),
        .data(in_reg[eng_ch]),
        .gain(gain_reg[eng_ch]),
        .zero(zero_reg[eng_ch]),
        .busy(eng_busy),
        .done(eng_done),
        .done_ch(eng_done_ch),
        .result(eng_result)
    );

    dcc_span_reload u_span_a (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .clear(soft_rst),
        .span(cfg.span_a),
        .trim(trim_a),
        .reload(reload_a),
        .code(code_a)
    );

    dcc_span_reload u_span_b (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .clear(soft_rst),
        .span(cfg.span_b),
        .trim(trim_b),
        .reload(reload_b),
        .code(code_b)
    );

    // ----------------------------------------------------------------------
    // Next-state logic.
    // ----------------------------------------------------------------------
    always_comb begin
        next_cfg = cfg;
        next_in_reg = in_reg;
        next_dac_reg = dac_reg;
        next_gain_reg = gain_reg;
        next_zero_reg = zero_reg;
        next_dac_latch = dac_latch;
        next_accessed = accessed;
        next_pend = pend;
        next_offset_a = offset_a;
        next_offset_b = offset_b;
        next_host_rdata = host_rdata;
        next_host_rvalid = host_req.rd;
        next_soft_rst = 1'b0;

        // Load pin low transfers every written channel and clears its mark.
        for (int i = 0; i < `DCC_NUM_CH; i++) begin
            if (!async_load_pin && accessed[i]) begin
                next_dac_latch[i] = dac_reg[i];
                next_accessed[i] = 1'b0;
            end
        end

        // Sync update loads only written channels, then the bit clears.
        if (fire) begin
            for (int i = 0; i < `DCC_NUM_CH; i++) begin
                if (accessed[i]) begin
                    next_dac_latch[i] = dac_reg[i];
                    next_accessed[i] = 1'b0;
                end
            end
            next_cfg.sync_latch_update = 1'b0;
        end

        if (eng_start) begin
            next_pend[eng_ch] = 1'b0;
        end

        // Corrected result lands in the converter register and marks the channel.
        if (eng_done) begin
            next_dac_reg[eng_done_ch] = eng_result;
            next_accessed[eng_done_ch] = 1'b1;
        end

        if (reload_a) begin
            next_offset_a = code_a;
        end
        if (reload_b) begin
            next_offset_b = code_b;
        end

        // Host writes; later assignments win so fresh marks are not lost.
        if (host_req.wr) begin
            if (host_req.addr == `DCC_ADDR_CFG) begin
                next_cfg.rdback_dac = host_req.wdata[`DCC_BIT_RDBACK];
                next_cfg.sync_latch_update = host_req.wdata[`DCC_BIT_LD] & async_load_pin;
                next_cfg.group_a_powerdown = host_req.wdata[`DCC_BIT_PD_A];
                next_cfg.group_b_powerdown = host_req.wdata[`DCC_BIT_PD_B];
                next_cfg.correction_engine_enable = host_req.wdata[`DCC_BIT_SCE];
                next_cfg.span_a = host_req.wdata[`DCC_BIT_SPAN_A];
                next_cfg.span_b = host_req.wdata[`DCC_BIT_SPAN_B];
                next_soft_rst = host_req.wdata[`DCC_BIT_RST];
            end else if (host_req.addr == `DCC_ADDR_OFS_A) begin
                next_offset_a = host_req.wdata;
            end else if (host_req.addr == `DCC_ADDR_OFS_B) begin
                next_offset_b = host_req.wdata;
            end else if (bank == `DCC_ADDR_DAC_BASE) begin
                next_in_reg[ach] = host_req.wdata;
                if (cfg.correction_engine_enable) begin
                    next_pend[ach] = 1'b1;
                end else begin
                    next_dac_reg[ach] = host_req.wdata;
                    next_accessed[ach] = 1'b1;
                end
            end else if (bank == `DCC_ADDR_ZERO_BASE) begin
                next_zero_reg[ach] = host_req.wdata;
            end else if (bank == `DCC_ADDR_GAIN_BASE) begin
                next_gain_reg[ach] = host_req.wdata;
            end
        end

        // Host reads; unmapped addresses answer zero.
        if (host_req.rd) begin
            next_host_rdata = 16'h0000;
            if (host_req.addr == `DCC_ADDR_CFG) begin
                next_host_rdata[`DCC_BIT_RDBACK] = cfg.rdback_dac;
                next_host_rdata[`DCC_BIT_LD] = cfg.sync_latch_update;
                next_host_rdata[`DCC_BIT_RST] = 1'b0;
                next_host_rdata[`DCC_BIT_PD_A] = cfg.group_a_powerdown;
                next_host_rdata[`DCC_BIT_PD_B] = cfg.group_b_powerdown;
                next_host_rdata[`DCC_BIT_SCE] = cfg.correction_engine_enable;
                next_host_rdata[`DCC_BIT_RSVD] = 1'b0;
                next_host_rdata[`DCC_BIT_SPAN_A] = cfg.span_a;
                next_host_rdata[`DCC_BIT_SPAN_B] = cfg.span_b;
            end else if (host_req.addr == `DCC_ADDR_OFS_A) begin
                next_host_rdata = offset_a;
            end else if (host_req.addr == `DCC_ADDR_OFS_B) begin
                next_host_rdata = offset_b;
            end else if (bank == `DCC_ADDR_DAC_BASE) begin
                next_host_rdata = cfg.rdback_dac ? dac_reg[ach] : in_reg[ach];
            end else if (bank == `DCC_ADDR_ZERO_BASE) begin
                next_host_rdata = zero_reg[ach];
            end else if (bank == `DCC_ADDR_GAIN_BASE) begin
                next_host_rdata = gain_reg[ach];
            end
        end

        // Software reset returns every register to its power-on value.
        if (soft_rst) begin
            next_cfg = dcc_pkg::dcc_cfg_s'({1'b1, 6'h00});
            next_accessed = 8'h00;
            next_pend = 8'h00;
            next_offset_a = `DCC_OFS_RESET;
            next_offset_b = `DCC_OFS_RESET;
            next_host_rdata = 16'h0000;
            next_host_rvalid = 1'b0;
            for (int i = 0; i < `DCC_NUM_CH; i++) begin
                next_in_reg[i] = `DCC_DATA_RESET;
                next_dac_reg[i] = `DCC_DATA_RESET;
                next_dac_latch[i] = `DCC_DATA_RESET;
                next_gain_reg[i] = `DCC_GAIN_RESET;
                next_zero_reg[i] = `DCC_ZERO_RESET;
            end
        end
    end

    // ----------------------------------------------------------------------
    // Registers.
    // ----------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            cfg <= dcc_pkg::dcc_cfg_s'({1'b1, 6'h00});
            accessed <= 8'h00;
            pend <= 8'h00;
            offset_a <= `DCC_OFS_RESET;
            offset_b <= `DCC_OFS_RESET;
            host_rdata <= 16'h0000;
            host_rvalid <= 1'b0;
            soft_rst <= 1'b0;
            for (int i = 0; i < `DCC_NUM_CH; i++) begin
                in_reg[i] <= `DCC_DATA_RESET;
                dac_reg[i] <= `DCC_DATA_RESET;
                dac_latch[i] <= `DCC_DATA_RESET;
                gain_reg[i] <= `DCC_GAIN_RESET;
                zero_reg[i] <= `DCC_ZERO_RESET;
            end
        end else begin
            cfg <= next_cfg;
            accessed <= next_accessed;
            pend <= next_pend;
            offset_a <= next_offset_a;
            offset_b <= next_offset_b;
            host_rdata <= next_host_rdata;
            host_rvalid <= next_host_rvalid;
            soft_rst <= next_soft_rst;
            in_reg <= next_in_reg;
            dac_reg <= next_dac_reg;
            dac_latch <= next_dac_latch;
            gain_reg <= next_gain_reg;
            zero_reg <= next_zero_reg;
        end
    end

endmodule

// ==== rtl/dcc_defs.svh ====
/*
 Constants of the configuration control block: register addresses, configuration
 bit positions, reset values and correction engine scaling.
 Assumes nothing of its surroundings; it holds definitions only.
*/
`ifndef DCC_DEFS_SVH
`define DCC_DEFS_SVH

// ----------------------------------------------------------------------
// Register addresses on the five-bit host address.
// ----------------------------------------------------------------------
`define DCC_ADDR_CFG 5'h00
`define DCC_ADDR_OFS_A 5'h03
`define DCC_ADDR_OFS_B 5'h04
`define DCC_ADDR_DAC_BASE 5'h08
`define DCC_ADDR_ZERO_BASE 5'h10
`define DCC_ADDR_GAIN_BASE 5'h18
`define DCC_ADDR_BANK_MASK 5'h18
`define DCC_ADDR_CH_MASK 5'h07

// ----------------------------------------------------------------------
// Configuration bit positions.
// ----------------------------------------------------------------------
`define DCC_BIT_RDBACK 15
`define DCC_BIT_LD 14
`define DCC_BIT_RST 13
`define DCC_BIT_PD_A 12
`define DCC_BIT_PD_B 11
`define DCC_BIT_SCE 10
`define DCC_BIT_RSVD 9
`define DCC_BIT_SPAN_A 8
`define DCC_BIT_SPAN_B 7

// ----------------------------------------------------------------------
// Reset values and channel range.
// ----------------------------------------------------------------------
`define DCC_CFG_RESET 16'h8000
`define DCC_GAIN_RESET 16'h8000
`define DCC_ZERO_RESET 16'h0000
`define DCC_DATA_RESET 16'h0000
`define DCC_OFS_RESET 16'h999a
`define DCC_CH_LAST 3'h7
`define DCC_NUM_CH 8

// ----------------------------------------------------------------------
// Correction scaling: unity gain code is two to the fifteenth.
// ----------------------------------------------------------------------
`define DCC_GAIN_SHIFT 15
`define DCC_CODE_MAX 16'hffff

`endif

// ==== rtl/dcc_pkg.sv ====
/*
 Types shared by the configuration control block.
 Assumes the constants of dcc_defs.svh for widths that matter to registers.
*/
package dcc_pkg;

    typedef logic [15:0] dcc_word_t;
    typedef logic [2:0] dcc_ch_t;

    // Stored configuration fields; the reserved bit and the reset bit are not stored.
    typedef struct packed {
        logic rdback_dac;
        logic sync_latch_update;
        logic group_a_powerdown;
        logic group_b_powerdown;
        logic correction_engine_enable;
        logic span_a;
        logic span_b;
    } dcc_cfg_s;

    // One host access from the serial front end.
    typedef struct packed {
        logic wr;
        logic rd;
        logic [4:0] addr;
        logic [15:0] wdata;
    } dcc_req_s;

    // Factory-trimmed offset codes of one group, one per span.
    typedef struct packed {
        logic [15:0] code_x6;
        logic [15:0] code_x4;
    } dcc_trim_s;

    typedef enum logic [1:0] {
        ENG_IDLE,
        ENG_MUL,
        ENG_ADD
    } dcc_eng_e;

endpackage

// ==== rtl/dcc_span_reload.sv ====
/*
 Span change detector of one channel group: emits a one-cycle reload pulse with
 the trimmed offset code whenever the span bit takes a new value, except while clear is high.
 Assumes the trim codes are static and clear is a synchronous soft reset.
*/
`timescale 1ns/10ps
`include "dcc_defs.svh"

module dcc_span_reload (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic clear,
    input wire logic span,
    input wire dcc_pkg::dcc_trim_s trim,
    output logic reload,
    output dcc_pkg::dcc_word_t code
);

    logic span_seen;
    logic next_span_seen;
    logic next_reload;
    dcc_pkg::dcc_word_t next_code;

    always_comb begin
        next_span_seen = span;
        next_reload = 1'b0;
        next_code = code;
        if (clear) begin
            next_span_seen = 1'b0;
        end else if (span != span_seen) begin
            next_reload = 1'b1;
            next_code = span ? trim.code_x4 : trim.code_x6;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            span_seen <= 1'b0;
            reload <= 1'b0;
            code <= `DCC_OFS_RESET;
        end else begin
            span_seen <= next_span_seen;
            reload <= next_reload;
            code <= next_code;
        end
    end

endmodule

// ==== rtl/dcc_correct.sv ====
/*
 Gain and zero correction engine: result = input * gain / 32768 + zero,
 clamped to the code range. Three cycles from start to done.
 Assumes start is only given while busy is low.
*/
`timescale 1ns/10ps
`include "dcc_defs.svh"

module dcc_correct (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic clear,
    input wire logic start,
    input wire dcc_pkg::dcc_ch_t start_ch,
    input wire dcc_pkg::dcc_word_t data,
    input wire dcc_pkg::dcc_word_t gain,
    input wire dcc_pkg::dcc_word_t zero,
    output logic busy,
    output logic done,
    output dcc_pkg::dcc_ch_t done_ch,
    output dcc_pkg::dcc_word_t result
);

    dcc_pkg::dcc_eng_e state;
    dcc_pkg::dcc_eng_e next_state;
    logic [31:0] product;
    logic [31:0] next_product;
    dcc_pkg::dcc_word_t zero_hold;
    dcc_pkg::dcc_word_t next_zero_hold;
    dcc_pkg::dcc_ch_t next_done_ch;
    dcc_pkg::dcc_word_t next_result;
    logic next_done;
    logic signed [18:0] sum;

    assign busy = (state != dcc_pkg::ENG_IDLE);
    assign sum = $signed({2'b00, product[31:`DCC_GAIN_SHIFT]}) + $signed({{3{zero_hold[15]}}, zero_hold});

    always_comb begin
        next_state = state;
        next_product = product;
        next_zero_hold = zero_hold;
        next_done_ch = done_ch;
        next_result = result;
        next_done = 1'b0;
        case (state)
            dcc_pkg::ENG_IDLE: begin
                if (start) begin
                    next_product = {16'h0000, data} * {16'h0000, gain};
                    next_zero_hold = zero;
                    next_done_ch = start_ch;
                    next_state = dcc_pkg::ENG_MUL;
                end
            end
            dcc_pkg::ENG_MUL: begin
                next_state = dcc_pkg::ENG_ADD;
            end
            dcc_pkg::ENG_ADD: begin
                if (sum < 0) begin
                    next_result = `DCC_DATA_RESET;
                end else if (|sum[17:16]) begin
                    next_result = `DCC_CODE_MAX;
                end else begin
                    next_result = sum[15:0];
                end
                next_done = 1'b1;
                next_state = dcc_pkg::ENG_IDLE;
            end
            default: begin
                next_state = dcc_pkg::ENG_IDLE;
            end
        endcase
        if (clear) begin
            next_state = dcc_pkg::ENG_IDLE;
            next_done = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            state <= dcc_pkg::ENG_IDLE;
            product <= 32'h0000_0000;
            zero_hold <= `DCC_ZERO_RESET;
            done_ch <= 3'h0;
            result <= `DCC_DATA_RESET;
            done <= 1'b0;
        end else begin
            state <= next_state;
            product <= next_product;
            zero_hold <= next_zero_hold;
            done_ch <= next_done_ch;
            result <= next_result;
            done <= next_done;
        end
    end

endmodule

// ==== verification/dcc_top_assertions.sv ====
/*
 Port checker of the configuration control top.
 Assumes binding into dcc_top; no host write reaches the offset registers.
*/
`timescale 1ns/10ps
module dcc_top_assertions (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire dcc_pkg::dcc_req_s host_req,
    input wire logic host_rvalid,
    input wire logic async_load_pin,
    input wire dcc_pkg::dcc_trim_s trim_a,
    input wire dcc_pkg::dcc_trim_s trim_b,
    input wire logic [7:0][15:0] dac_latch,
    input wire logic [7:0] output_enable,
    input wire logic group_a_powerdown,
    input wire logic group_b_powerdown,
    input wire logic span_a_x4,
    input wire logic span_b_x4,
    input wire dcc_pkg::dcc_word_t offset_a,
    input wire dcc_pkg::dcc_word_t offset_b,
    input wire logic correction_busy
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    sequence dac_direct;
        host_req.wr && host_req.addr[4:3] == 2'h1 && !async_load_pin ##1 !async_load_pin && !correction_busy;
    endsequence
    rd_answer_a: assert property (host_req.rd |=> host_rvalid)
        else $error("read got no answer");
    oe_group_a_a: assert property (output_enable[3:0] == {4{!group_a_powerdown}})
        else $error("group a enable wrong");
    oe_group_b_a: assert property (output_enable[7:4] == {4{!group_b_powerdown}})
        else $error("group b enable wrong");
    pd_cause_a: assert property ($changed(group_a_powerdown) |->
        $past(host_req.wr && host_req.addr == 5'h00) || $past(host_req.wr && host_req.addr == 5'h00, 2))
        else $error("power-down changed with no write");
    reload_a_a: assert property ($changed(span_a_x4) |->
        ##2 offset_a == (span_a_x4 ? trim_a.code_x4 : trim_a.code_x6))
        else $error("offset a not reloaded");
    reload_b_a: assert property ($changed(span_b_x4) |->
        ##2 offset_b == (span_b_x4 ? trim_b.code_x4 : trim_b.code_x6))
        else $error("offset b not reloaded");
    no_reload_a: assert property ($changed(offset_a) |-> $past(span_a_x4, 2) != $past(span_a_x4, 3))
        else $error("offset a changed without span change");
    direct_load_a: assert property (dac_direct |=>
        dac_latch[$past(host_req.addr[2:0], 2)] == $past(host_req.wdata, 2))
        else $error("latch missed direct load");
endmodule
bind dcc_top dcc_top_assertions dcc_top_assertions_i (.*);

// ==== verification/dcc_host_model.sv ====
/*
 Host model: one register access at a time on the host port.
 Assumes the read answer stands in the cycle after the read strobe.
*/
`timescale 1ns/10ps
module dcc_host_model (
    input wire logic sys_clk,
    input wire logic host_rvalid,
    input wire dcc_pkg::dcc_word_t host_rdata,
    output dcc_pkg::dcc_req_s host_req
);
    initial host_req = '0;
    task automatic wr(input logic [4:0] a, input dcc_pkg::dcc_word_t d);
        @(posedge sys_clk);
        host_req <= {1'b1, 1'b0, a, d};
        @(posedge sys_clk);
        host_req <= {1'b0, 1'b0, ~a, ~d};
    endtask
    task automatic rd(input logic [4:0] a, output dcc_pkg::dcc_word_t d);
        @(posedge sys_clk);
        host_req <= {1'b0, 1'b1, a, 16'h0000};
        @(posedge sys_clk);
        host_req <= {1'b0, 1'b0, ~a, 16'hffff};
        @(negedge sys_clk);
        d = (host_rvalid === 1'b1) ? host_rdata : 16'hxxxx;
    endtask
endmodule

// ==== verification/dac_config_control_test.sv ====
/*
 Bench of the configuration control block: a table of register accesses, then
 correction, latch update, span reload and soft reset cases.
 Assumes the host model is the only driver of the register port.
*/
`timescale 1ns/10ps
module dac_config_control_test;
    typedef struct packed {
        logic w;
        logic [4:0] addr;
        logic [15:0] wdata;
        logic [15:0] exp;
        logic [7:0] oe;
    } dcc_row_s;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic async_load_pin = 1'b0;
    dcc_pkg::dcc_trim_s trim_a = {16'h999a, 16'h4000};
    dcc_pkg::dcc_trim_s trim_b = {16'h999a, 16'h2000};
    dcc_pkg::dcc_req_s host_req;
    dcc_pkg::dcc_word_t host_rdata;
    dcc_pkg::dcc_word_t rd_val;
    dcc_pkg::dcc_word_t offset_a;
    dcc_pkg::dcc_word_t offset_b;
    logic host_rvalid;
    logic [7:0][15:0] dac_latch;
    logic [7:0] output_enable;
    logic group_a_powerdown;
    logic group_b_powerdown;
    logic span_a_x4;
    logic span_b_x4;
    logic correction_busy;
    int n_mismatch = 0;
    int check_count = 0;
    dcc_row_s rows [9] = '{{1'b0, 5'h00, 16'h0000, 16'h8000, 8'hff}, {1'b0, 5'h18, 16'h0000, 16'h8000, 8'hff},
        {1'b0, 5'h03, 16'h0000, 16'h999a, 8'hff}, {1'b1, 5'h05, 16'hffff, 16'h0000, 8'hff},
        {1'b1, 5'h00, 16'h1a00, 16'h1800, 8'h00}, {1'b1, 5'h00, 16'h0800, 16'h0800, 8'h0f},
        {1'b1, 5'h00, 16'h0000, 16'h0000, 8'hff}, {1'b1, 5'h0a, 16'h1234, 16'h1234, 8'hff},
        {1'b1, 5'h1a, 16'h4000, 16'h4000, 8'hff}};
    always #2.5 sys_clk = ~sys_clk;
    dcc_top dcc_top_i (.*);
    dcc_host_model dcc_host_model_i (.*);
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic rd_chk(input logic [4:0] a, input logic [15:0] exp);
        dcc_host_model_i.rd(a, rd_val);
        chk(rd_val, exp);
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic wait_idle;
        int n;
        for (n = 0; n < 50 && correction_busy !== 1'b0; n++) @(negedge sys_clk);
        if (correction_busy !== 1'b0) begin
            n_mismatch++;
            end_sim;
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] d, input int gap);
        dcc_host_model_i.wr(a, d);
        repeat (gap) @(posedge sys_clk);
        @(negedge sys_clk);
    endtask
    initial begin
        repeat (5) @(posedge sys_clk);
        nrst <= 1'b1;
        foreach (rows[i]) begin
            if (rows[i].w) dcc_host_model_i.wr(rows[i].addr, rows[i].wdata);
            rd_chk(rows[i].addr, rows[i].exp);
            chk({8'h00, output_enable}, {8'h00, rows[i].oe});
        end
        chk(dac_latch[2], 16'h1234);
        @(posedge sys_clk);
        async_load_pin <= 1'b1;
        wr(5'h00, 16'h8400, 0);
        wr(5'h0a, 16'h1000, 0);
        wait_idle;
        rd_chk(5'h0a, 16'h0800);
        wr(5'h00, 16'h0400, 0);
        rd_chk(5'h0a, 16'h1000);
        chk(dac_latch[2], 16'h1234);
        wr(5'h00, 16'h4400, 2);
        chk(dac_latch[2], 16'h0800);
        chk(dac_latch[0], 16'h0000);
        rd_chk(5'h00, 16'h0400);
        wr(5'h00, 16'h0000, 0);
        wr(5'h0b, 16'h5555, 0);
        chk(dac_latch[3], 16'h0000);
        wr(5'h00, 16'h4000, 2);
        chk(dac_latch[3], 16'h5555);
        @(posedge sys_clk);
        async_load_pin <= 1'b0;
        wr(5'h00, 16'h4000, 0);
        rd_chk(5'h00, 16'h0000);
        wr(5'h00, 16'h0100, 3);
        chk(offset_a, 16'h4000);
        chk({15'h0000, span_a_x4}, 16'h0001);
        wr(5'h00, 16'h0180, 3);
        chk(offset_a, 16'h4000);
        chk(offset_b, 16'h2000);
        chk({15'h0000, span_b_x4}, 16'h0001);
        wr(5'h00, 16'h0000, 3);
        chk(offset_a, 16'h999a);
        rd_chk(5'h04, 16'h999a);
        wr(5'h00, 16'h1000, 0);
        chk({15'h0000, group_a_powerdown}, 16'h0001);
        wr(5'h00, 16'h2000, 1);
        rd_chk(5'h00, 16'h8000);
        chk(dac_latch[3], 16'h0000);
        chk({8'h00, output_enable}, 16'h00ff);
        end_sim;
    end
endmodule
